// *** tdcac_pkg.sv ***
// Summary of operation
// - Every counter and measurement is taken on rising edges of the chip clock.
// - Bunch count reset presets coarse, trigger tag, event and reject counters to offsets.
// - Trigger latency equals coarse offset minus trigger tag offset, modulo 4096.
// - An event is too old once its age exceeds coarse minus reject offset.
// - All counters wrap at the roll-over value; larger settings add nothing.
// - Effective match and search spans are one cycle above their settings.
// - Effective mask span equals its setting exactly.
// - A 46-bit buffer word holds rejected, edge, parities, coarse counts and fine bits.
// - Without pair mode the edge bit is 1 for leading and 0 for trailing.
// - In pair mode the edge bit is 0 when the trailing edge was found.
// - The rejected flag marks data following a discard caused by a full buffer.
// - Each channel buffer holds four entries; hits arriving when full are discarded.
package tdcac_pkg;
  localparam int CNT_W = 12;
  localparam int CH_NUM = 24;
  localparam int BUF_DEPTH = 4;
  localparam int FINE_W = 16;
  localparam int CRS_W = 13;
  localparam int WORD_W = 46;
  localparam int PAIR_W = 92;
  localparam int BIT_REJECTED = 45;
  localparam int BIT_EDGE = 44;
  localparam int BIT_C2_PAR = 43;
  localparam int C2_LSB = 30;
  localparam int BIT_C1_PAR = 29;
  localparam int C1_LSB = 16;
  localparam int FINE_LSB = 0;
  localparam logic [CNT_W-1:0] RST_COUNT = 12'h000;
  // Counter indices inside the alignment counter set.
  typedef enum logic [1:0] {
    TDCAC_CNT_COARSE = 2'b00,
    TDCAC_CNT_TAG = 2'b01,
    TDCAC_CNT_EVENT = 2'b10,
    TDCAC_CNT_REJECT = 2'b11
  } tdcac_cnt_t;
endpackage

// *** tdcac_counters.sv ***
`timescale 1ns/100ps
module tdcac_counters #(
  parameter int CHANNELS = 24,
  parameter int DEPTH = 4
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bunch_rst_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] mask_span_setting_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] search_span_setting_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] match_span_setting_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] reject_counter_preset_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] event_id_preset_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] trigger_tag_preset_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] coarse_counter_preset_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] counter_wrap_limit_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] channel_enable_low_reg_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] channel_enable_high_reg_in,
  input wire logic enable_pair_in,
  input wire logic enable_rejected_in,
  input wire logic hit_valid_in,
  input wire logic [4:0] hit_ch_in,
  input wire logic hit_edge_in,
  input wire logic hit_trail_found_in,
  input wire logic [tdcac_pkg::FINE_W-1:0] hit_fine_in,
  input wire logic [tdcac_pkg::CNT_W-1:0] age_coarse_in,
  input wire logic rd_en_in,
  input wire logic [4:0] rd_ch_in,
  output logic [tdcac_pkg::CNT_W-1:0] coarse_count_out,
  output logic [tdcac_pkg::CNT_W-1:0] trigger_tag_out,
  output logic [tdcac_pkg::CNT_W-1:0] event_id_out,
  output logic [tdcac_pkg::CNT_W-1:0] reject_count_out,
  output logic [tdcac_pkg::CNT_W-1:0] latency_out,
  output logic [tdcac_pkg::CNT_W-1:0] reject_limit_out,
  output logic [tdcac_pkg::CNT_W:0] match_span_eff_out,
  output logic [tdcac_pkg::CNT_W:0] search_span_eff_out,
  output logic [tdcac_pkg::CNT_W-1:0] mask_span_eff_out,
  output logic too_old_out,
  output logic [CHANNELS-1:0] buf_full_out,
  output logic rd_valid_out,
  output logic [tdcac_pkg::PAIR_W-1:0] rd_data_out
);
  import tdcac_pkg::*;

  // Pointer, count and enable widths only serve the documented sizes.
  if (CHANNELS != CH_NUM || DEPTH != BUF_DEPTH)
  begin : g_size_check
    $error("Channel count and buffer depth must keep their documented values.");
  end

  logic [CNT_W-1:0] cnt_r [4];
  logic [CNT_W-1:0] cnt_nxt [4];
  logic [CNT_W-1:0] preset [4];
  logic [CNT_W-1:0] latency_r;
  logic [CNT_W-1:0] latency_nxt;
  logic [CNT_W-1:0] limit_r;
  logic [CNT_W-1:0] limit_nxt;
  logic too_old_r;
  logic too_old_nxt;
  logic [CNT_W-1:0] age;
  logic [2*CNT_W-1:0] ch_enable;
  logic [CRS_W-1:0] crs;
  logic [WORD_W-1:0] word_base;
  logic [WORD_W-1:0] head0 [CHANNELS];
  logic [WORD_W-1:0] head1 [CHANNELS];
  logic [CHANNELS-1:0] pop;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [PAIR_W-1:0] rd_data_r;
  logic [PAIR_W-1:0] rd_data_nxt;

  // Each counter loads its own offset from the preset registers.
  assign preset[TDCAC_CNT_COARSE] = coarse_counter_preset_reg_in;
  assign preset[TDCAC_CNT_TAG] = trigger_tag_preset_reg_in;
  assign preset[TDCAC_CNT_EVENT] = event_id_preset_reg_in;
  assign preset[TDCAC_CNT_REJECT] = reject_counter_preset_reg_in;

  // The four alignment counters share the roll-over limit and the bunch reset.
  for (genvar k = 0; k < 4; k++)
  begin : g_cnt
    always_comb
    begin
      if (bunch_rst_in)
        cnt_nxt[k] = preset[k];
      else if (cnt_r[k] >= counter_wrap_limit_reg_in)
        cnt_nxt[k] = RST_COUNT;
      else
        cnt_nxt[k] = cnt_r[k] + 12'h001;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
        cnt_r[k] <= RST_COUNT;
      else
        cnt_r[k] <= cnt_nxt[k];
    end
  end

  // Latency and reject limit follow from offset differences, modulo 4096.
  assign age = coarse_count_out - age_coarse_in;
  always_comb
  begin
    latency_nxt = coarse_counter_preset_reg_in - trigger_tag_preset_reg_in;
    limit_nxt = coarse_counter_preset_reg_in - reject_counter_preset_reg_in;
    too_old_nxt = age > limit_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      latency_r <= RST_COUNT;
      limit_r <= RST_COUNT;
      too_old_r <= 1'b0;
    end
    else
    begin
      latency_r <= latency_nxt;
      limit_r <= limit_nxt;
      too_old_r <= too_old_nxt;
    end
  end

  assign coarse_count_out = cnt_r[TDCAC_CNT_COARSE];
  assign trigger_tag_out = cnt_r[TDCAC_CNT_TAG];
  assign event_id_out = cnt_r[TDCAC_CNT_EVENT];
  assign reject_count_out = cnt_r[TDCAC_CNT_REJECT];
  assign latency_out = latency_r;
  assign reject_limit_out = limit_r;
  assign too_old_out = too_old_r;

  // Effective window sizes seen by the matching logic.
  assign match_span_eff_out = {1'b0, match_span_setting_reg_in} + 13'h0001;
  assign search_span_eff_out = {1'b0, search_span_setting_reg_in} + 13'h0001;
  assign mask_span_eff_out = mask_span_setting_reg_in;

  // Measurement word without the rejected flag; the channel adds it.
  assign ch_enable = {channel_enable_high_reg_in, channel_enable_low_reg_in};
  assign crs = {1'b0, coarse_count_out};
  always_comb
  begin
    word_base = '0;
    word_base[BIT_EDGE] = enable_pair_in ? ~hit_trail_found_in : hit_edge_in;
    word_base[BIT_C2_PAR] = ^crs;
    word_base[C2_LSB +: CRS_W] = crs;
    word_base[BIT_C1_PAR] = ^crs;
    word_base[C1_LSB +: CRS_W] = crs;
    word_base[FINE_LSB +: FINE_W] = hit_fine_in;
  end

  // Per-channel four-entry buffer; a hit on a full buffer is dropped.
  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_ch
    logic [WORD_W-1:0] mem_r [DEPTH];
    logic [WORD_W-1:0] mem_nxt [DEPTH];
    logic [2:0] count_r;
    logic [2:0] count_nxt;
    logic [1:0] wp_r;
    logic [1:0] wp_nxt;
    logic [1:0] rp_r;
    logic [1:0] rp_nxt;
    logic pend_r;
    logic pend_nxt;
    logic wr;
    logic store;
    logic drop;
    logic [2:0] need;

    assign wr = hit_valid_in && (hit_ch_in == 5'(c)) && ch_enable[c];
    assign store = wr && (count_r != 3'(DEPTH));
    assign drop = wr && (count_r == 3'(DEPTH));
    assign need = enable_pair_in ? 3'h2 : 3'h1;
    assign pop[c] = rd_en_in && (rd_ch_in == 5'(c)) && (count_r >= need);
    assign head0[c] = mem_r[rp_r];
    assign head1[c] = mem_r[rp_r + 2'h1];
    assign buf_full_out[c] = (count_r == 3'(DEPTH));

    always_comb
    begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      count_nxt = count_r;
      if (store)
      begin
        mem_nxt[wp_r] = word_base;
        mem_nxt[wp_r][BIT_REJECTED] = pend_r;
        wp_nxt = wp_r + 2'h1;
      end
      if (pop[c])
        rp_nxt = rp_r + need[1:0];
      count_nxt = count_r + (store ? 3'h1 : 3'h0) - (pop[c] ? need : 3'h0);
      // A new discard wins over the clear made by a store.
      if (drop && enable_rejected_in)
        pend_nxt = 1'b1;
      else if (store)
        pend_nxt = 1'b0;
      else
        pend_nxt = pend_r;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        for (int i = 0; i < DEPTH; i++)
          mem_r[i] <= '0;
        wp_r <= 2'h0;
        rp_r <= 2'h0;
        count_r <= 3'h0;
        pend_r <= 1'b0;
      end
      else
      begin
        mem_r <= mem_nxt;
        wp_r <= wp_nxt;
        rp_r <= rp_nxt;
        count_r <= count_nxt;
        pend_r <= pend_nxt;
      end
    end

    a_full_discard: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      drop && !pop[c] |=> count_r == 3'(DEPTH) && wp_r == $past(wp_r))
      else $error("Hit on a full buffer was stored.");
    a_reject_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      store |=> mem_r[$past(wp_r)][BIT_REJECTED] == $past(pend_r))
      else $error("Rejected flag does not follow the pending discard.");
  end

  // Read port: first measurement in the low half, second in the high half.
  always_comb
  begin
    rd_valid_nxt = |pop;
    rd_data_nxt = rd_data_r;
    if (|pop)
      rd_data_nxt = {enable_pair_in ? head1[rd_ch_in] : {WORD_W{1'b0}}, head0[rd_ch_in]};
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end
    else
    begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_valid_out = rd_valid_r;
  assign rd_data_out = rd_data_r;

  // Counter and alignment checks.
  a_preset_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bunch_rst_in |=> coarse_count_out == $past(coarse_counter_preset_reg_in)
    && trigger_tag_out == $past(trigger_tag_preset_reg_in))
    else $error("Counters not preset on bunch reset.");
  a_counter_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !bunch_rst_in && reject_count_out >= counter_wrap_limit_reg_in
    |=> reject_count_out == 12'h000)
    else $error("Reject counter did not wrap at the limit.");
  a_counter_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !bunch_rst_in && event_id_out < counter_wrap_limit_reg_in
    |=> event_id_out == $past(event_id_out) + 12'h001)
    else $error("Event counter did not step by one.");
  a_latency_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $stable(coarse_counter_preset_reg_in) && $stable(trigger_tag_preset_reg_in)
    |=> latency_out
    == 12'($past(coarse_counter_preset_reg_in) - $past(trigger_tag_preset_reg_in)))
    else $error("Latency differs from offset difference.");
  a_old_event: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    12'(coarse_count_out - age_coarse_in) > reject_limit_out |=> too_old_out)
    else $error("Old event not flagged.");
  a_young_event: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    12'(coarse_count_out - age_coarse_in) <= reject_limit_out |=> !too_old_out)
    else $error("Event within the limit flagged as too old.");

  // Window sizes and measurement word layout.
  a_match_plus1: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    search_span_eff_out == {1'b0, search_span_setting_reg_in} + 13'h0001
    && match_span_eff_out == {1'b0, match_span_setting_reg_in} + 13'h0001)
    else $error("Effective span is not setting plus one.");
  a_mask_exact: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mask_span_eff_out == mask_span_setting_reg_in)
    else $error("Mask span differs from its setting.");
  a_edge_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_base[BIT_EDGE] == (enable_pair_in ? !hit_trail_found_in : hit_edge_in)
    && word_base[BIT_C1_PAR] == ^word_base[C1_LSB +: CRS_W])
    else $error("Edge or parity bit wrong in measurement word.");

  // Read data stands until the next pop.
  a_data_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(|pop) |=> $stable(rd_data_out))
    else $error("Read data changed without a pop.");
endmodule

// *** tdcac_hit_source.sv ***
`timescale 1ns/100ps
module tdcac_hit_source (
  input wire logic clk_in,
  output logic bunch_rst_out,
  output logic hit_valid_out,
  output logic [4:0] hit_ch_out,
  output logic hit_edge_out,
  output logic hit_trail_found_out,
  output logic [tdcac_pkg::FINE_W-1:0] hit_fine_out
);
  import tdcac_pkg::*;
  // Idle hit fields are inverted after each pulse so stale values never look valid.
  initial
  begin
    bunch_rst_out = 1'b0;
    hit_valid_out = 1'b0;
    hit_ch_out = 5'h1F;
    hit_edge_out = 1'b0;
    hit_trail_found_out = 1'b0;
    hit_fine_out = 16'hA5A5;
  end
  // One discriminator pulse, launched at a falling edge and held for one full cycle.
  task automatic fire(input logic [4:0] ch, input logic e, input logic tf, input logic [15:0] f);
    hit_ch_out = ch;
    hit_edge_out = e;
    hit_trail_found_out = tf;
    hit_fine_out = f;
    hit_valid_out = 1'b1;
    @(negedge clk_in);
    hit_valid_out = 1'b0;
    hit_ch_out = ~ch;
    hit_edge_out = ~e;
    hit_trail_found_out = ~tf;
    hit_fine_out = ~f;
  endtask
  // One-cycle bunch count reset from the timing distribution.
  task automatic bunch();
    bunch_rst_out = 1'b1;
    @(negedge clk_in);
    bunch_rst_out = 1'b0;
  endtask
endmodule

// *** test_tdc_time_alignment_counters.sv ***
`timescale 1ns/100ps
module test_tdc_time_alignment_counters;
  import tdcac_pkg::*;
  logic clk_in, rst_n_in, bunch_rst, hv, he, htf, pair, rej_en, rd_en, too_old, rd_valid;
  logic [4:0] hch, rd_ch, ch;
  logic [15:0] hf, lf;
  logic [11:0] mask, srch, mtch, rej, evo, tag, crs, lim, en_lo, en_hi, age, cc, cm;
  logic [11:0] c_crs, c_tag, c_ev, c_rej, lat, rlim, mske;
  logic [12:0] mtche, srche;
  logic [23:0] full;
  logic [91:0] rdd;
  logic [45:0] w [0:4];
  int n_errors, n_checks;
  tdcac_hit_source src (.clk_in(clk_in), .bunch_rst_out(bunch_rst), .hit_valid_out(hv),
    .hit_ch_out(hch), .hit_edge_out(he), .hit_trail_found_out(htf), .hit_fine_out(hf));
  tdcac_counters DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .bunch_rst_in(bunch_rst),
    .mask_span_setting_reg_in(mask), .search_span_setting_reg_in(srch),
    .match_span_setting_reg_in(mtch), .reject_counter_preset_reg_in(rej),
    .event_id_preset_reg_in(evo), .trigger_tag_preset_reg_in(tag),
    .coarse_counter_preset_reg_in(crs), .counter_wrap_limit_reg_in(lim),
    .channel_enable_low_reg_in(en_lo), .channel_enable_high_reg_in(en_hi),
    .enable_pair_in(pair), .enable_rejected_in(rej_en), .hit_valid_in(hv), .hit_ch_in(hch),
    .hit_edge_in(he), .hit_trail_found_in(htf), .hit_fine_in(hf), .age_coarse_in(age),
    .rd_en_in(rd_en), .rd_ch_in(rd_ch), .coarse_count_out(c_crs), .trigger_tag_out(c_tag),
    .event_id_out(c_ev), .reject_count_out(c_rej), .latency_out(lat), .reject_limit_out(rlim),
    .match_span_eff_out(mtche), .search_span_eff_out(srche), .mask_span_eff_out(mske),
    .too_old_out(too_old), .buf_full_out(full), .rd_valid_out(rd_valid), .rd_data_out(rdd));
  // Free-running 20 MHz chip clock.
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Reference coarse counter, kept from the rules alone.
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      cm <= 12'h000;
    else
      cm <= bunch_rst ? crs : nxt(cm);
  // Pseudo-random source, a fixed-seed shift register.
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  // Random offset no greater than the roll-over value.
  function automatic logic [11:0] pick();
    return 12'(rnd() % (lim + 13'h0001));
  endfunction
  // Next counter value: step by one, back to zero after the roll-over value.
  function automatic logic [11:0] nxt(input logic [11:0] v);
    return (v >= lim) ? 12'h000 : v + 12'h001;
  endfunction
  // Expected buffer word, with the even parity of each widened coarse field.
  function automatic logic [45:0] wrd(input logic r, input logic e, input logic [15:0] f);
    return {r, e, ^cc, 1'b0, cc, ^cc, 1'b0, cc, f};
  endfunction
  task automatic chk(input logic [91:0] got, input logic [91:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // Pops one entry (or a pair) and compares it with the expected word.
  task automatic pop(input logic [91:0] exp);
    rd_ch = ch;
    rd_en = 1'b1;
    @(negedge clk_in);
    rd_en = 1'b0;
    chk(rd_valid, 1'b1, "read strobe");
    chk(rdd, exp, "buffer word");
    @(negedge clk_in);
    chk(rd_valid, 1'b0, "read strobe end");
    chk(rdd, exp, "read data hold");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 1000 cycles.
  initial
  begin
    #(50 * 5000);
    n_errors++;
    conclude();
  end
  // Main sequence: counters and alignment, then channel buffer behaviour.
  initial
  begin
    {rst_n_in, pair, rej_en, rd_en, rd_ch, age, mask, srch, mtch, rej, evo, tag, crs} = '0;
    lf = 16'd37280;
    lim = 12'hDEB;
    en_lo = 12'hFFF;
    en_hi = 12'hFFF;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      lim = 12'(12'h900 + rnd() % 12'h6FF);
      srch = 12'(rnd() & 16'h00FF);
      mask = 12'(rnd());
      mtch = 12'(rnd());
      rej = pick();
      evo = pick();
      tag = pick();
      crs = pick();
      if (i == 0)
        crs = lim;
      rej = crs - ((crs - tag) + 12'h008);
      @(negedge clk_in);
      src.bunch();
      chk({c_crs, c_tag, c_ev, c_rej}, {crs, tag, evo, rej}, "preset values");
      chk(lat, 12'(crs - tag), "latency");
      chk(rlim, 12'(crs - rej), "reject limit");
      chk(mtche, {1'b0, mtch} + 13'h0001, "match span");
      chk(srche, {1'b0, srch} + 13'h0001, "search span");
      chk(mske, mask, "mask span");
      age = i[0] ? 12'(rnd()) : 12'(cm - (crs - rej));
      cc = cm;
      @(negedge clk_in);
      chk({c_crs, c_tag, c_ev, c_rej}, {nxt(crs), nxt(tag), nxt(evo), nxt(rej)}, "step");
      chk(too_old, (cc - age) > (crs - rej), "age test");
      $display("alignment pass %0d done", i);
    end
    rej_en = 1'b1;
    ch = 5'(rnd() % 16'd24);
    for (int k = 0; k < 5; k++)
    begin
      cc = cm;
      w[k] = wrd(1'b0, k[0], rnd());
      src.fire(ch, k[0], 1'b0, w[k][15:0]);
      @(negedge clk_in);
      chk(full[ch], k >= 3, "buffer full");
    end
    for (int k = 0; k < 4; k++)
      pop({46'h0, w[k]});
    cc = cm;
    w[4] = wrd(1'b1, 1'b1, 16'h5A3C);
    src.fire(ch, 1'b1, 1'b0, 16'h5A3C);
    @(negedge clk_in);
    pop({46'h0, w[4]});
    $display("buffer test done");
    rst_n_in = 1'b0;
    @(negedge clk_in);
    chk({c_crs, c_tag, c_ev, c_rej, full, rd_valid}, '0, "reset state");
    chk(rdd, '0, "reset data");
    rst_n_in = 1'b1;
    @(negedge clk_in);
    chk(c_crs, nxt(12'h000), "restart count");
    {en_hi, en_lo} = ~(24'h000001 << ch);
    src.fire(ch, 1'b1, 1'b0, 16'h1234);
    {en_hi, en_lo} = 24'hFFFFFF;
    @(negedge clk_in);
    cc = cm;
    w[0] = wrd(1'b0, 1'b1, 16'hC3E1);
    src.fire(ch, 1'b1, 1'b0, 16'hC3E1);
    @(negedge clk_in);
    pop({46'h0, w[0]});
    $display("reset and enable test done");
    pair = 1'b1;
    ch = 5'((ch + 5'd1) % 5'd24);
    for (int k = 0; k < 2; k++)
    begin
      cc = cm;
      w[k] = wrd(1'b0, k[0], rnd());
      src.fire(ch, 1'b1, ~k[0], w[k][15:0]);
      @(negedge clk_in);
    end
    pop({w[1], w[0]});
    $display("pair test done");
    conclude();
  end
endmodule
